// ### core/ptc_top.sv
// Timestamp capture block with a register slave.
// Operation
// R1 - Skew control adjusts one-step transmit timestamps by lane.
// R2 - Tag write failure sets sticky write fault.
// R3 - Tag read failure sets sticky read fault.
// R4 - Ordinary mode time: 48-bit seconds, 32-bit nanoseconds.
// R5 - Transparent mode: sign, nanoseconds, fraction fields.
// R6 - Time input arrives on the lane 0 clock.
// R7 - Timestamp valid with client start of packet.
// R8 - Timestamp layout equals time input layout.
// R9 - Five-bit lane index valid with start.
// R10 - Report seven-bit fill level per lane.
// R11 - Outside logic may compensate skew using fills.
// R12 - Lane index ranges zero to nineteen only.
`timescale 1ns/10ps
module ptc_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [ptc_pkg::TIME_W-1:0] rx_sys_time,
    input wire logic [ptc_pkg::SEG_N-1:0] rx_sop_in,
    input wire logic [ptc_pkg::LANE_W-1:0] rx_sop_lane_in,
    output logic [ptc_pkg::SEG_N-1:0] rx_sop_out,
    output logic [ptc_pkg::TIME_W-1:0] rx_ts_out,
    output logic [ptc_pkg::LANE_W-1:0] rx_lane_out,
    input wire logic [ptc_pkg::LANES-1:0] lane_push,
    input wire logic [ptc_pkg::LANES-1:0] lane_pop,
    output logic [ptc_pkg::LANES*ptc_pkg::FILL_W-1:0] lane_fill_out,
    input wire logic tx_sop_in,
    input wire logic tx_one_step,
    input wire logic [ptc_pkg::LANE_W-1:0] tx_sop_lane_in,
    input wire logic [ptc_pkg::TIME_W-1:0] tx_ts_in,
    output logic tx_ts_valid_out,
    output logic [ptc_pkg::TIME_W-1:0] tx_ts_out,
    input wire logic tx_path_reset,
    input wire logic tag_push,
    input wire logic tag_pop,
    output logic tag_wr_fault,
    output logic tag_rd_fault
);
    typedef struct packed {
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic skew_en;
        logic [7:0] step;
        logic [ptc_pkg::SEG_N-1:0] rx_sop;
        logic [ptc_pkg::TIME_W-1:0] rx_ts;
        logic [ptc_pkg::LANE_W-1:0] rx_lane;
        logic tx_v;
        logic [ptc_pkg::TIME_W-1:0] tx_ts;
        logic [ptc_pkg::TAG_CNT_W-1:0] tag_cnt;
        logic wr_fault;
        logic rd_fault;
    } ptc_state_s;

    ptc_state_s st;
    ptc_state_s next_st;
    logic [ptc_pkg::LANES*ptc_pkg::FILL_W-1:0] fill;

    // True for lanes zero to nineteen.
    function automatic logic lane_ok(input logic [ptc_pkg::LANE_W-1:0] lane);
        lane_ok = (lane <= ptc_pkg::LANE_LAST);
    endfunction

    // Applies byte strobes.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = r;
    endfunction

    // ========================================================================
    // Lane fill counters.
    // ========================================================================
    ptc_lane_fill ptc_lane_fill_inst (
        .aclk(aclk),
        .aresetn(aresetn),
        .lane_push(lane_push),
        .lane_pop(lane_pop),
        .lane_fill(fill)
    );

    // ========================================================================
    // Next-state logic.
    // ========================================================================
    // Next state of every part.
    always_comb begin
        logic [31:0] cur;
        logic [31:0] adj;
        logic wr_err;
        logic rd_err;
        logic [4:0] fidx;
        cur = '0;
        adj = '0;
        wr_err = 1'b0;
        rd_err = 1'b0;
        fidx = '0;
        next_st = st;
        // Address and data in either order; response after both.
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.aw_got && st.w_got && !st.bvalid) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = ptc_pkg::RESP_OKAY;
            unique case (st.awaddr)
                ptc_pkg::OFS_CTRL: begin
                    cur = merge({31'h0, st.skew_en}, st.wdata, st.wstrb);
                    next_st.skew_en = cur[ptc_pkg::CTRL_SKEW_BIT];
                end
                ptc_pkg::OFS_STEP: begin
                    cur = merge({24'h0, st.step}, st.wdata, st.wstrb);
                    next_st.step = cur[7:0];
                end
                ptc_pkg::OFS_STATUS, ptc_pkg::OFS_TS0, ptc_pkg::OFS_TS1, ptc_pkg::OFS_TS2: begin
                    next_st.bresp = ptc_pkg::RESP_OKAY;
                end
                default: begin
                    next_st.bresp = ptc_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        // Reads answer one cycle after the address is taken.
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = ptc_pkg::RESP_OKAY;
            next_st.rdata = '0;
            if (s_axi_araddr == ptc_pkg::OFS_CTRL) begin
                next_st.rdata[ptc_pkg::CTRL_SKEW_BIT] = st.skew_en;
            end else if (s_axi_araddr == ptc_pkg::OFS_STATUS) begin
                next_st.rdata[ptc_pkg::STAT_WRF_BIT] = st.wr_fault;
                next_st.rdata[ptc_pkg::STAT_RDF_BIT] = st.rd_fault;
                next_st.rdata[ptc_pkg::STAT_LANE_POS +: ptc_pkg::LANE_W] = st.rx_lane;
                next_st.rdata[ptc_pkg::STAT_CNT_POS +: ptc_pkg::TAG_CNT_W] = st.tag_cnt;
            end else if (s_axi_araddr == ptc_pkg::OFS_TS0) begin
                next_st.rdata = st.rx_ts[31:0];
            end else if (s_axi_araddr == ptc_pkg::OFS_TS1) begin
                next_st.rdata = st.rx_ts[63:32];
            end else if (s_axi_araddr == ptc_pkg::OFS_TS2) begin
                next_st.rdata = {16'h0, st.rx_ts[79:64]};
            end else if (s_axi_araddr == ptc_pkg::OFS_STEP) begin
                next_st.rdata = {24'h0, st.step};
            end else if (s_axi_araddr >= ptc_pkg::OFS_FILL0 && s_axi_araddr <= ptc_pkg::OFS_FILL4
                         && s_axi_araddr[1:0] == 2'h0) begin
                // Four lanes per word, lowest lane in the low byte.
                fidx = 5'(((s_axi_araddr - ptc_pkg::OFS_FILL0) >> 2) * 8'h04);
                for (int k = 0; k < 4; k++) begin
                    next_st.rdata[k*8 +: ptc_pkg::FILL_W] = fill[(int'(fidx) + k)*ptc_pkg::FILL_W +: ptc_pkg::FILL_W];
                end
            end else begin
                next_st.rresp = ptc_pkg::RESP_SLVERR;
            end
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // Time sampled at the capture plane, start passed on.
        next_st.rx_sop = rx_sop_in; // [R7]
        if (|rx_sop_in) begin
            next_st.rx_ts = rx_sys_time; // [R6] [R7] [R8]
            if (lane_ok(rx_sop_lane_in)) begin
                next_st.rx_lane = rx_sop_lane_in; // [R9] [R12]
            end
        end
        // One-step stamps gain lane times step in the low word.
        if (st.skew_en && tx_one_step && lane_ok(tx_sop_lane_in)) begin
            adj = 32'(tx_sop_lane_in) * 32'(st.step); // [R1]
        end
        next_st.tx_v = tx_sop_in;
        if (tx_sop_in) begin
            next_st.tx_ts = {tx_ts_in[79:ptc_pkg::NS_W], tx_ts_in[ptc_pkg::NS_W-1:0] + adj}; // [R1]
        end
        // Tag count and sticky faults; a new fault beats the reset.
        wr_err = tag_push && (st.tag_cnt == ptc_pkg::TAG_FULL) && !tag_pop;
        rd_err = tag_pop && (st.tag_cnt == 5'h00);
        if (tx_path_reset) begin
            next_st.tag_cnt = '0;
        end else if (tag_push && !wr_err && !(tag_pop && !rd_err)) begin
            next_st.tag_cnt = st.tag_cnt + 5'h01;
        end else if (tag_pop && !rd_err && !tag_push) begin
            next_st.tag_cnt = st.tag_cnt - 5'h01;
        end
        next_st.wr_fault = (st.wr_fault && !tx_path_reset) || wr_err; // [R2]
        next_st.rd_fault = (st.rd_fault && !tx_path_reset) || rd_err; // [R3]
    end

    // Registers the whole state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.skew_en <= ptc_pkg::RST_SKEW;
            st.step <= ptc_pkg::RST_STEP;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================================
    // Outputs.
    // ========================================================================
    assign s_axi_awready = !st.aw_got && !st.bvalid;
    assign s_axi_wready = !st.w_got && !st.bvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign rx_sop_out = st.rx_sop;
    assign rx_ts_out = st.rx_ts;
    assign rx_lane_out = st.rx_lane;
    assign lane_fill_out = fill; // [R10]
    assign tx_ts_valid_out = st.tx_v;
    assign tx_ts_out = st.tx_ts;
    assign tag_wr_fault = st.wr_fault;
    assign tag_rd_fault = st.rd_fault;

    // ========================================================================
    // Checks.
    // ========================================================================
    sequence rx_start_s;
        |rx_sop_in;
    endsequence
    sequence tx_plain_s;
        tx_sop_in && !(st.skew_en && tx_one_step);
    endsequence
    property rx_ts_p;
        @(posedge aclk) disable iff (!aresetn)
        rx_start_s |=> (|rx_sop_out) && rx_ts_out == $past(rx_sys_time);
    endproperty
    rx_ts_capture_a: assert property (rx_ts_p) else $error("Timestamp not aligned with start."); // [R7] [R8]
    property rx_lane_p;
        @(posedge aclk) disable iff (!aresetn)
        (rx_start_s and lane_ok(rx_sop_lane_in)) |=> rx_lane_out == $past(rx_sop_lane_in);
    endproperty
    rx_lane_capture_a: assert property (rx_lane_p) else $error("Lane index not captured."); // [R9]
    lane_range_a: assert property (@(posedge aclk) disable iff (!aresetn) rx_lane_out <= 5'h13)
        else $error("Lane index out of range."); // [R12]
    property tx_plain_p;
        @(posedge aclk) disable iff (!aresetn)
        tx_plain_s |=> tx_ts_valid_out && tx_ts_out == $past(tx_ts_in);
    endproperty
    tx_no_adjust_a: assert property (tx_plain_p) else $error("Timestamp altered without adjust."); // [R1]
    property tx_adj_p;
        @(posedge aclk) disable iff (!aresetn)
        (tx_sop_in && st.skew_en && tx_one_step && lane_ok(tx_sop_lane_in))
            |=> tx_ts_out[31:0] == $past(tx_ts_in[31:0]) + 32'($past(tx_sop_lane_in)) * 32'($past(st.step));
    endproperty
    tx_lane_adjust_a: assert property (tx_adj_p) else $error("Lane adjust wrong."); // [R1]
    property wr_fault_p;
        @(posedge aclk) disable iff (!aresetn)
        (tag_push && !tag_pop && st.tag_cnt == 5'h10) |=> tag_wr_fault ##1 (tag_wr_fault || $past(tx_path_reset));
    endproperty
    wr_fault_set_a: assert property (wr_fault_p) else $error("Write fault not raised or held."); // [R2]
    property rd_fault_p;
        @(posedge aclk) disable iff (!aresetn)
        (tag_rd_fault && !tx_path_reset) |=> tag_rd_fault;
    endproperty
    rd_fault_hold_a: assert property (rd_fault_p) else $error("Read fault cleared without reset."); // [R3]
    rd_fault_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (tag_pop && st.tag_cnt == 5'h00) |=> tag_rd_fault) else $error("Read fault not raised."); // [R3]
    fill_floor_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (lane_pop[0] && !lane_push[0] && lane_fill_out[6:0] == 7'h00) |=> lane_fill_out[6:0] == 7'h00)
        else $error("Empty lane fill went below zero."); // [R10]
endmodule

// ### inc/ptc_pkg.sv
// Package of constants for the receive and transmit timestamp capture block.
package ptc_pkg;
    // ========================================================================
    // Geometry of the lanes, the time words and the tag queue.
    // ========================================================================
    localparam int LANES = 20;
    localparam int LANE_W = 5;
    localparam int FILL_W = 7;
    localparam int TIME_W = 80;
    localparam int SEG_N = 4;
    localparam int TAG_DEPTH = 16;
    localparam int TAG_CNT_W = 5;
    localparam logic [LANE_W-1:0] LANE_LAST = 5'h13;
    localparam logic [FILL_W-1:0] FILL_MAX = 7'h7f;
    localparam logic [TAG_CNT_W-1:0] TAG_FULL = 5'h10;

    // ========================================================================
    // Register byte offsets.
    // ========================================================================
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_TS0 = 8'h08;
    localparam logic [7:0] OFS_TS1 = 8'h0c;
    localparam logic [7:0] OFS_TS2 = 8'h10;
    localparam logic [7:0] OFS_STEP = 8'h14;
    localparam logic [7:0] OFS_FILL0 = 8'h20;
    localparam logic [7:0] OFS_FILL4 = 8'h30;

    // ========================================================================
    // Field positions and reset values.
    // ========================================================================
    localparam int CTRL_SKEW_BIT = 0;
    localparam int STAT_WRF_BIT = 0;
    localparam int STAT_RDF_BIT = 1;
    localparam int STAT_LANE_POS = 8;
    localparam int STAT_CNT_POS = 16;
    localparam int NS_W = 32;
    localparam logic RST_SKEW = 1'b0;
    localparam logic [7:0] RST_STEP = 8'h00;

    // ========================================================================
    // Bus response codes.
    // ========================================================================
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### core/ptc_lane_fill.sv
// Per-lane deskew buffer fill level counters.
`timescale 1ns/10ps
module ptc_lane_fill (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ptc_pkg::LANES-1:0] lane_push,
    input wire logic [ptc_pkg::LANES-1:0] lane_pop,
    output logic [ptc_pkg::LANES*ptc_pkg::FILL_W-1:0] lane_fill
);
    typedef struct packed {
        logic [ptc_pkg::LANES-1:0][ptc_pkg::FILL_W-1:0] lvl;
    } ptc_fill_s;

    ptc_fill_s st;
    ptc_fill_s next_st;

    // ========================================================================
    // Counting.
    // ========================================================================
    // Each lane counts words held in its buffer, saturating at both ends.
    always_comb begin
        next_st = st;
        for (int i = 0; i < ptc_pkg::LANES; i++) begin
            if (lane_push[i] && !lane_pop[i] && st.lvl[i] != ptc_pkg::FILL_MAX) begin
                next_st.lvl[i] = st.lvl[i] + 7'h01; // [R10]
            end else if (lane_pop[i] && !lane_push[i] && st.lvl[i] != 7'h00) begin
                next_st.lvl[i] = st.lvl[i] - 7'h01; // [R10]
            end
        end
    end

    // Registers the state.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign lane_fill = st.lvl;

    // ========================================================================
    // Checks.
    // ========================================================================
    property fill_up_p;
        @(posedge aclk) disable iff (!aresetn)
        (lane_push[3] && !lane_pop[3] && st.lvl[3] != ptc_pkg::FILL_MAX) |=> (st.lvl[3] == $past(st.lvl[3]) + 7'h01);
    endproperty
    fill_count_up_a: assert property (fill_up_p) else $error("Lane fill did not count up."); // [R10]
    property fill_hold_p;
        @(posedge aclk) disable iff (!aresetn)
        (lane_push[19] == lane_pop[19]) |=> $stable(st.lvl[19]);
    endproperty
    fill_hold_a: assert property (fill_hold_p) else $error("Lane fill moved without net traffic."); // [R10]
endmodule

// ### verif/ptc_ts_user.sv
// Client-side timestamping partner model.
`timescale 1ns/10ps
module ptc_ts_user (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic tc_mode,
    input wire logic [ptc_pkg::SEG_N-1:0] req_seg,
    input wire logic [ptc_pkg::LANE_W-1:0] req_lane,
    output logic [ptc_pkg::TIME_W-1:0] rx_sys_time,
    output logic [ptc_pkg::SEG_N-1:0] rx_sop_in,
    output logic [ptc_pkg::LANE_W-1:0] rx_sop_lane_in
);
    logic [47:0] secs;
    logic [31:0] nsec;
    logic [62:0] tc_time;

    // ========================================================================
    // Time keeping
    // ========================================================================
    // Both formats tick on the lane 0 clock.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            secs <= 48'h0000_0000_0001;
            nsec <= 32'h3b9a_c99c;
            tc_time <= 63'h0;
        end else begin
            tc_time <= tc_time + 63'h32_8000;
            if (nsec >= 32'h3b9a_c9ce) begin
                nsec <= nsec - 32'h3b9a_c9ce;
                secs <= secs + 48'h1;
            end else begin
                nsec <= nsec + 32'h32;
            end
        end
    end

    // Ordinary or transparent time format.
    assign rx_sys_time = tc_mode ? {16'h0, 1'b0, tc_time} : {secs, nsec};

    // Starts on request; lane code is not held between starts.
    always_ff @(posedge aclk) begin
        rx_sop_in <= req_seg;
        rx_sop_lane_in <= (req_seg != 4'h0) ? req_lane : ~rx_sop_lane_in;
    end
endmodule

// ### verif/ptp_rx_timestamp_capture_tb.sv
// Self-checking bench for the timestamp capture block.
`timescale 1ns/10ps
module ptp_rx_timestamp_capture_tb;
    localparam logic [79:0] TX_TS = 80'h1234_0000_0001_ffff_fff0;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, tx_sop_in, tx_one_step, tx_ts_valid_out;
    logic tx_path_reset, tag_push, tag_pop, tag_wr_fault, tag_rd_fault, tc_mode;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [79:0] rx_sys_time, rx_ts_out, tx_ts_in, tx_ts_out;
    logic [3:0] rx_sop_in, rx_sop_out, req_seg;
    logic [4:0] rx_sop_lane_in, rx_lane_out, tx_sop_lane_in, req_lane;
    logic [19:0] lane_push, lane_pop;
    logic [139:0] lane_fill_out;
    int n_mismatch, compares;

    ptc_top ptc_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_sys_time,
        .rx_sop_in, .rx_sop_lane_in, .rx_sop_out, .rx_ts_out, .rx_lane_out, .lane_push, .lane_pop, .lane_fill_out,
        .tx_sop_in, .tx_one_step, .tx_sop_lane_in, .tx_ts_in, .tx_ts_valid_out, .tx_ts_out, .tx_path_reset,
        .tag_push, .tag_pop, .tag_wr_fault, .tag_rd_fault);
    ptc_ts_user ptc_ts_user_inst (.aclk, .aresetn, .tc_mode, .req_seg, .req_lane, .rx_sys_time, .rx_sop_in,
        .rx_sop_lane_in);

    // Free-running 20 MHz clock.
    always #25 aclk = ~aclk;

    // ========================================================================
    // Checking and closing
    // ========================================================================
    // Compares one value and counts the result.
    task automatic check_val(input string what, input logic [79:0] exp, input logic [79:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ========================================================================
    // Register bus master
    // ========================================================================
    // Writes one word and returns the response.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        bit done;
        done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
        if (!done) begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    // Reads and checks one word.
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
        int n;
        bit done;
        done = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40 && !done; n++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                check_val(what, 80'(exp), 80'(s_axi_rdata));
                check_val(what, 80'(er), 80'(s_axi_rresp));
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
        if (!done) begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    // ========================================================================
    // Data path tasks
    // ========================================================================
    // Requests a start and checks its capture.
    task automatic rx_start(input logic [3:0] seg, input logic [4:0] lane, input logic [4:0] lane_exp);
        logic [79:0] t;
        @(posedge aclk);
        req_seg <= seg;
        req_lane <= lane;
        @(posedge aclk);
        req_seg <= 4'h0;
        #1;
        t = rx_sys_time;
        @(posedge aclk);
        #1;
        check_val("rx start", 80'(seg), 80'(rx_sop_out));
        check_val("rx stamp", t, rx_ts_out);
        check_val("rx lane", 80'(lane_exp), 80'(rx_lane_out));
    endtask

    // Offers a transmit stamp and checks the result.
    task automatic tx_chk(input logic os, input logic [4:0] lane, input logic [79:0] exp);
        @(posedge aclk);
        tx_sop_in <= 1'b1;
        tx_one_step <= os;
        tx_sop_lane_in <= lane;
        tx_ts_in <= TX_TS;
        @(posedge aclk);
        tx_sop_in <= 1'b0;
        tx_ts_in <= ~TX_TS;
        #1;
        check_val("tx valid", 80'(1), 80'(tx_ts_valid_out));
        check_val("tx stamp", exp, tx_ts_out);
    endtask

    // ========================================================================
    // Main sequence
    // ========================================================================
    // The test sequence.
    initial begin
        {aclk, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
        {tx_sop_in, tx_one_step, tx_path_reset, tag_push, tag_pop, tc_mode, aresetn} = 7'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tx_ts_in} = 128'h0;
        {req_seg, req_lane, tx_sop_lane_in, lane_push, lane_pop} = 54'h0;
        s_axi_wstrb = 4'hf;
        n_mismatch = 0;
        compares = 0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        reg_chk(ptc_pkg::OFS_CTRL, 32'h0, ptc_pkg::RESP_OKAY, "ctrl reset");
        reg_chk(ptc_pkg::OFS_STEP, 32'h0, ptc_pkg::RESP_OKAY, "step reset");
        reg_chk(ptc_pkg::OFS_STATUS, 32'h0, ptc_pkg::RESP_OKAY, "status reset");
        reg_chk(8'h40, 32'h0, ptc_pkg::RESP_SLVERR, "unmapped read");
        axi_wr(8'h44, 32'hffff_ffff, rsp);
        check_val("unmapped write", 80'(ptc_pkg::RESP_SLVERR), 80'(rsp));
        axi_wr(ptc_pkg::OFS_STATUS, 32'hffff_ffff, rsp);
        reg_chk(ptc_pkg::OFS_STATUS, 32'h0, ptc_pkg::RESP_OKAY, "status read only");
        axi_wr(ptc_pkg::OFS_STEP, 32'h4, rsp);
        axi_wr(ptc_pkg::OFS_CTRL, 32'h1, rsp);
        reg_chk(ptc_pkg::OFS_STEP, 32'h4, ptc_pkg::RESP_OKAY, "step");
        reg_chk(ptc_pkg::OFS_CTRL, 32'h1, ptc_pkg::RESP_OKAY, "ctrl");
        rx_start(4'h1, 5'd7, 5'd7);
        rx_start(4'h8, 5'd19, 5'd19);
        reg_chk(ptc_pkg::OFS_STATUS, 32'h0000_1300, ptc_pkg::RESP_OKAY, "status lane");
        tc_mode <= 1'b1;
        rx_start(4'h2, 5'd0, 5'd0);
        rx_start(4'h4, 5'd20, 5'd0);
        tx_chk(1'b1, 5'd5, 80'h1234_0000_0001_0000_0004);
        tx_chk(1'b1, 5'd19, 80'h1234_0000_0001_0000_003c);
        tx_chk(1'b0, 5'd5, TX_TS);
        tx_chk(1'b1, 5'd25, TX_TS);
        axi_wr(ptc_pkg::OFS_CTRL, 32'h0, rsp);
        tx_chk(1'b1, 5'd5, TX_TS);
        // Lane 3: two pushes, then push with pop; lane 19 one push; lane 0 pops empty.
        @(posedge aclk);
        lane_push <= 20'h8_0008;
        lane_pop <= 20'h0_0001;
        @(posedge aclk);
        lane_push <= 20'h0_0008;
        lane_pop <= 20'h0;
        @(posedge aclk);
        lane_pop <= 20'h0_0008;
        @(posedge aclk);
        lane_push <= 20'h0;
        lane_pop <= 20'h0;
        #1;
        check_val("fill lane 3", 80'(2), 80'(lane_fill_out[21 +: 7]));
        check_val("fill lane 19", 80'(1), 80'(lane_fill_out[133 +: 7]));
        check_val("fill lane 0", 80'(0), 80'(lane_fill_out[0 +: 7]));
        reg_chk(ptc_pkg::OFS_FILL0, 32'h0200_0000, ptc_pkg::RESP_OKAY, "fill word 0");
        reg_chk(ptc_pkg::OFS_FILL4, 32'h0100_0000, ptc_pkg::RESP_OKAY, "fill word 4");
        // Sixteen tags fill the queue; the seventeenth fails.
        @(posedge aclk);
        tag_push <= 1'b1;
        repeat (16) @(posedge aclk);
        #1;
        check_val("wr fault at full", 80'(0), 80'(tag_wr_fault));
        @(posedge aclk);
        tag_push <= 1'b0;
        #1;
        check_val("wr fault", 80'(1), 80'(tag_wr_fault));
        repeat (5) @(posedge aclk);
        reg_chk(ptc_pkg::OFS_STATUS, 32'h0010_0001, ptc_pkg::RESP_OKAY, "status wr fault");
        @(posedge aclk);
        tx_path_reset <= 1'b1;
        @(posedge aclk);
        tx_path_reset <= 1'b0;
        tag_pop <= 1'b1;
        @(posedge aclk);
        tag_pop <= 1'b0;
        #1;
        check_val("wr fault cleared", 80'(0), 80'(tag_wr_fault));
        check_val("rd fault", 80'(1), 80'(tag_rd_fault));
        reg_chk(ptc_pkg::OFS_STATUS, 32'h0000_0002, ptc_pkg::RESP_OKAY, "status rd fault");
        @(posedge aclk);
        tx_path_reset <= 1'b1;
        @(posedge aclk);
        tx_path_reset <= 1'b0;
        #1;
        check_val("rd fault cleared", 80'(0), 80'(tag_rd_fault));
        end_of_test();
    end
endmodule
